/* File: rtl/perf_count_pkg.sv */
// Constants shared by the line error performance counters.
// Assumes a 200 MHz i_mclk and single clock domain.
package perf_count_pkg;

  // ********************************************************
  // Counter geometry
  // ********************************************************
  localparam int          CNT_W        = 16;
  localparam logic [15:0] CNT_MAX      = 16'hffff;
  localparam logic [15:0] CNT_RESET    = 16'h0000;
  localparam int          HALF_W       = 8;

  // ********************************************************
  // Configuration bit positions
  // ********************************************************
  localparam int CFG_LINE_SEL_BIT = 0;
  localparam int CFG_SYNC_SEL_BIT = 1;
  localparam int CFG_FS_EN_BIT    = 2;
  localparam int CFG_W            = 3;

  // ********************************************************
  // Update source select codes
  // ********************************************************
  localparam logic [1:0] UPD_SECOND = 2'h0;
  localparam logic [1:0] UPD_FAST   = 2'h1;
  localparam logic [1:0] UPD_MANUAL = 2'h2;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam longint CLK_HZ          = 200000000;
  localparam longint SECOND_NS       = 1000000000;
  localparam longint T1_FAST_US      = 42000;
  localparam longint E1_FAST_NS      = 62500000;
  localparam longint SECOND_CYCLES   = SECOND_NS * CLK_HZ / 1000000000;
  localparam longint T1_FAST_CYCLES  = T1_FAST_US * CLK_HZ / 1000000;
  localparam longint E1_FAST_CYCLES  = E1_FAST_NS * CLK_HZ / 1000000000;
  localparam int     TIMER_W         = 28;

  // ********************************************************
  // Zero run lengths
  // ********************************************************
  localparam logic [4:0] ZERO_RUN_AMI  = 5'h10;
  localparam logic [4:0] ZERO_RUN_B8ZS = 5'h08;

endpackage

/* File: rtl/sat_counter.sv */
// Saturating accumulator with snapshot on update.
// Assumes synchronous active high reset on i_mclk.
`timescale 1ns/1ps
module sat_counter (
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_inc,
  input  wire logic        i_update,
  output logic [15:0]      o_count
);

  logic [15:0] acc_reg;
  logic [15:0] acc_next;
  logic [15:0] acc_plus;
  wire         at_max = (acc_reg == perf_count_pkg::CNT_MAX);

  // Stops at full scale, never wraps  [R03]
  assign acc_plus = at_max ? acc_reg : acc_reg + 16'h0001;
  // Snapshot then restart; an event on the update cycle opens the next
  // interval only, so no event is ever reported twice
  assign acc_next = i_update ? (i_inc ? 16'h0001 : perf_count_pkg::CNT_RESET)
                             : (i_inc ? acc_plus : acc_reg);  // [R21]

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      acc_reg <= perf_count_pkg::CNT_RESET;
      o_count <= perf_count_pkg::CNT_RESET;
    end else begin
      acc_reg <= acc_next;
      if (i_update) begin
        o_count <= acc_reg;  // [R21]
      end
    end
  end

  a_never_wraps: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (acc_reg == perf_count_pkg::CNT_MAX && !i_update)
      |=> acc_reg == perf_count_pkg::CNT_MAX)  // [R03]
    else $error("accumulator left full scale");

  a_snapshot_restart: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    i_update |=> (acc_reg == {15'h0000, $past(i_inc)} &&
                  o_count == $past(acc_reg)))  // [R21]
    else $error("snapshot or restart wrong");

endmodule

/* File: rtl/line_error_performance_counters.sv */
// Line error performance counters for a T1/E1 receive framer.
// Assumes framer and decoder strobes arrive on i_mclk; the
// manual update pin is asynchronous and is synchronised here.
//
// Summary of operation
// R01: Four counters: line, path, sync, far-end.
// R02: Update on second, 42ms, 62.5ms or manual.
// R03: Counters saturate, never wrap to zero.
// R04: Latch on second or external manual input.
// R05: Same-polarity consecutive marks are bipolar violations.
// R06: Valid B8ZS/HDB3 codewords not counted as violations.
// R07: E1 select 1 counts code violations instead.
// R08: T1 adds 16 or 8 zero runs.
// R09: Line counter ignores sync loss, saturates 65535.
// R10: T1 path counts CRC-6, Ft, optionally Fs.
// R11: T1 path counter inhibited during frame loss.
// R12: E1 path counts CRC-4, inhibited on FAS/CRC-4 loss.
// R13: Sixteen-bit count split into high, low halves.
// R14: T1 multiframe out-of-sync count ignores frame loss.
// R15: T1 F-bit error count inhibited by frame loss.
// R16: E1 sync counts FAS errors, not while searching.
// R17: E1 far-end counts zero E-bits frames 13, 15.
// R18: Host picks violation type to suit line code.
// R19: Timer pulse marks each automatic update.
// R20: Frame loss is real-time, high while unsynchronised.
// R21: Accumulator copied out then restarted each update.
`timescale 1ns/1ps
module line_error_performance_counters (
  input  wire logic       i_mclk,
  input  wire logic       i_sys_rst,
  // Mode and configuration
  input  wire logic       i_e1_mode,
  input  wire logic       i_esf_mode,
  input  wire logic       i_crc4_mode,
  input  wire logic       i_zcs_enable,
  input  wire logic [2:0] i_counter_configuration,
  input  wire logic [1:0] i_update_select,
  input  wire logic       i_manual_update,
  // Line decoder
  input  wire logic       i_mark_valid,
  input  wire logic       i_mark_pos,
  input  wire logic       i_mark_neg,
  input  wire logic       i_codeword_valid,
  // Framer events and status
  input  wire logic       i_crc_error,
  input  wire logic       i_ft_error,
  input  wire logic       i_fs_error,
  input  wire logic       i_fps_error,
  input  wire logic       i_fas_error,
  input  wire logic       i_multiframe_end,
  input  wire logic       i_multiframe_out_of_sync,
  input  wire logic       i_ebit_valid,
  input  wire logic       i_ebit_value,
  input  wire logic [3:0] i_frame_number,
  input  wire logic       i_receive_frame_loss,
  input  wire logic       i_fas_sync_loss,
  input  wire logic       i_crc4_sync_loss,
  input  wire logic       i_cas_sync_loss,
  input  wire logic       i_fas_search,
  input  wire logic       i_cas_search,
  input  wire logic       i_crc4_search,
  // Results
  output logic [7:0]      o_line_violation_count_hi,
  output logic [7:0]      o_line_violation_count_lo,
  output logic [7:0]      o_path_violation_count_hi,
  output logic [7:0]      o_path_violation_count_lo,
  output logic [7:0]      o_sync_error_count_hi,
  output logic [7:0]      o_sync_error_count_lo,
  output logic [7:0]      o_far_end_block_count_hi,
  output logic [7:0]      o_far_end_block_count_lo,
  output logic            o_frame_loss,
  output logic            o_update_timer_pulse
);

  // ********************************************************
  // Manual update synchroniser and edge detect
  // ********************************************************
  logic manual_meta_reg;
  logic manual_sync_reg;
  logic manual_prev_reg;
  wire  manual_event = manual_sync_reg & ~manual_prev_reg;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      manual_meta_reg <= 1'b0;
      manual_sync_reg <= 1'b0;
      manual_prev_reg <= 1'b0;
    end else begin
      manual_meta_reg <= i_manual_update;
      manual_sync_reg <= manual_meta_reg;
      manual_prev_reg <= manual_sync_reg;
    end
  end

  // ********************************************************
  // Update interval timer
  // ********************************************************
  localparam logic [27:0] SEC_LAST =
    28'(perf_count_pkg::SECOND_CYCLES - 1);
  localparam logic [27:0] T1_LAST =
    28'(perf_count_pkg::T1_FAST_CYCLES - 1);
  localparam logic [27:0] E1_LAST =
    28'(perf_count_pkg::E1_FAST_CYCLES - 1);

  logic [27:0] timer_reg;
  logic [27:0] timer_next;
  logic        timer_pulse_reg;
  wire         sel_fast   = (i_update_select == perf_count_pkg::UPD_FAST);
  wire         sel_manual = (i_update_select == perf_count_pkg::UPD_MANUAL);
  // Fast interval follows the line standard  [R02]
  wire  [27:0] timer_last = !sel_fast ? SEC_LAST
                          : (i_e1_mode ? E1_LAST : T1_LAST);
  wire         timer_wrap = (timer_reg >= timer_last);

  assign timer_next = timer_wrap ? 28'h000_0000 : timer_reg + 28'h000_0001;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      timer_reg       <= 28'h000_0000;
      timer_pulse_reg <= 1'b0;
    end else begin
      timer_reg       <= timer_next;
      timer_pulse_reg <= timer_wrap;
    end
  end

  // Manual pin replaces the timer as the latch source  [R04]
  wire update_strobe = sel_manual ? manual_event : timer_pulse_reg;
  // Timer pulse for host read scheduling in automatic modes  [R19]
  assign o_update_timer_pulse = timer_pulse_reg & ~sel_manual;
  // Frame loss reported live  [R20]
  assign o_frame_loss = i_receive_frame_loss;

  // ********************************************************
  // Bipolar and code violation detection
  // ********************************************************
  logic last_pol_reg;
  logic have_mark_reg;
  logic last_bpv_pol_reg;
  logic have_bpv_reg;
  logic [4:0] zero_run_reg;
  logic [4:0] zero_run_next;

  wire mark_now = i_mark_valid & (i_mark_pos ^ i_mark_neg);
  wire zero_now = i_mark_valid & ~i_mark_pos & ~i_mark_neg;
  // Consecutive marks of one polarity  [R05]
  wire raw_bpv  = mark_now & have_mark_reg & (i_mark_pos == last_pol_reg);
  // Substitution codewords exempt when decoding enabled  [R06]
  wire bpv      = raw_bpv & ~(i_zcs_enable & i_codeword_valid);
  // Two BPVs of the same polarity in a row  [R07]
  wire cv       = bpv & have_bpv_reg & (i_mark_pos == last_bpv_pol_reg);
  wire [4:0] zero_limit = i_zcs_enable ? perf_count_pkg::ZERO_RUN_B8ZS
                                       : perf_count_pkg::ZERO_RUN_AMI;
  wire zero_hit = zero_now & (zero_run_next == zero_limit);
  wire line_sel = i_counter_configuration[perf_count_pkg::CFG_LINE_SEL_BIT];

  assign zero_run_next = !zero_now ? 5'h00
                       : (zero_run_reg == zero_limit) ? 5'h01
                       : zero_run_reg + 5'h01;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      last_pol_reg     <= 1'b0;
      have_mark_reg    <= 1'b0;
      last_bpv_pol_reg <= 1'b0;
      have_bpv_reg     <= 1'b0;
      zero_run_reg     <= 5'h00;
    end else begin
      if (mark_now) begin
        last_pol_reg  <= i_mark_pos;
        have_mark_reg <= 1'b1;
      end
      if (bpv) begin
        last_bpv_pol_reg <= i_mark_pos;
        have_bpv_reg     <= 1'b1;
      end
      if (i_mark_valid) begin
        zero_run_reg <= zero_run_next;
      end
    end
  end

  // No sync inhibit on the line counter  [R09]
  wire line_inc = i_e1_mode ? (line_sel ? cv : bpv)                // [R07]
                            : (bpv | (line_sel & zero_hit));       // [R08]

  // ********************************************************
  // Path, sync and far-end event qualification
  // ********************************************************
  wire fs_en   = i_counter_configuration[perf_count_pkg::CFG_FS_EN_BIT];
  wire fbit_md = i_counter_configuration[perf_count_pkg::CFG_SYNC_SEL_BIT];
  wire e1_lost = i_fas_sync_loss | i_crc4_sync_loss;

  wire t1_path = i_esf_mode ? i_crc_error
                            : (i_ft_error | (fs_en & i_fs_error)); // [R10]
  wire path_inc = i_e1_mode ? (i_crc_error & ~e1_lost)             // [R12]
                            : (t1_path & ~i_receive_frame_loss);   // [R11]

  wire t1_mos  = i_multiframe_end & i_multiframe_out_of_sync;      // [R14]
  wire t1_fbit = (i_esf_mode ? i_fps_error : i_ft_error)
               & ~i_receive_frame_loss;                            // [R15]
  wire e1_sync = i_fas_error & ~i_receive_frame_loss & ~i_fas_search
               & ~i_cas_search & ~i_crc4_search;                   // [R16]
  wire sync_inc = i_e1_mode ? e1_sync : (fbit_md ? t1_fbit : t1_mos);

  wire ebit_frame = (i_frame_number == 4'hd) | (i_frame_number == 4'hf);
  wire febe_inc = i_e1_mode & i_crc4_mode & i_ebit_valid & ~i_ebit_value
                & ebit_frame & ~e1_lost;                           // [R17]

  // ********************************************************
  // Four saturating counters
  // ********************************************************
  logic [15:0] line_count;
  logic [15:0] path_count;
  logic [15:0] sync_count;
  logic [15:0] febe_count;

  sat_counter u_line_cnt (                                         // [R01]
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_inc     (line_inc),
    .i_update  (update_strobe),
    .o_count   (line_count)
  );
  sat_counter u_path_cnt (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_inc     (path_inc),
    .i_update  (update_strobe),
    .o_count   (path_count)
  );
  sat_counter u_sync_cnt (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_inc     (sync_inc),
    .i_update  (update_strobe),
    .o_count   (sync_count)
  );
  sat_counter u_febe_cnt (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_inc     (febe_inc),
    .i_update  (update_strobe),
    .o_count   (febe_count)
  );

  // High half first register, low half second  [R13]
  assign o_line_violation_count_hi = line_count[15:8];
  assign o_line_violation_count_lo = line_count[7:0];
  assign o_path_violation_count_hi = path_count[15:8];
  assign o_path_violation_count_lo = path_count[7:0];
  assign o_sync_error_count_hi     = sync_count[15:8];
  assign o_sync_error_count_lo     = sync_count[7:0];
  assign o_far_end_block_count_hi  = febe_count[15:8];
  assign o_far_end_block_count_lo  = febe_count[7:0];

  // ********************************************************
  // Checks
  // ********************************************************
  a_path_t1_inhibit: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    (!i_e1_mode && i_receive_frame_loss) |-> !path_inc)  // [R11]
    else $error("T1 path counted during frame loss");

  a_path_e1_inhibit: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    (i_e1_mode && e1_lost) |-> (!path_inc && !febe_inc))  // [R12]
    else $error("E1 path or far-end counted during sync loss");

  a_line_bpv_count: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    (!i_e1_mode && bpv) |-> line_inc)  // [R09]
    else $error("violation not counted");

  a_codeword_exempt: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    (i_zcs_enable && i_codeword_valid && !line_sel) |-> !line_inc)  // [R06]
    else $error("codeword counted as violation");

  a_sync_search_off: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    (i_e1_mode && (i_fas_search || i_cas_search || i_crc4_search))
      |-> !sync_inc)  // [R16]
    else $error("FAS error counted while searching");

  a_fbit_inhibit: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    (!i_e1_mode && fbit_md && i_receive_frame_loss) |-> !sync_inc)  // [R15]
    else $error("F-bit error counted during frame loss");

  a_febe_frames: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    febe_inc |-> (ebit_frame && i_crc4_mode))  // [R17]
    else $error("far-end count outside frames 13 and 15");

  a_manual_latch: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    (sel_manual && $rose(manual_sync_reg)) |-> update_strobe)  // [R04]
    else $error("manual update not applied");

  a_timer_period: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    timer_wrap |=> (timer_reg == 28'h000_0000 && timer_pulse_reg))  // [R02]
    else $error("interval timer did not restart");

  c_manual_update: cover property (@(posedge i_mclk)
    sel_manual && update_strobe);
  c_line_count: cover property (@(posedge i_mclk) line_inc && zero_hit);
  c_e1_febe: cover property (@(posedge i_mclk) febe_inc);
  c_code_violation: cover property (@(posedge i_mclk) i_e1_mode && cv);
  c_cas_loss_count: cover property (@(posedge i_mclk)
    i_e1_mode && i_cas_sync_loss && path_inc);

endmodule

/* File: verification/line_error_performance_counters_test.sv */
// Self-checking bench for the line error performance counters.
// Assumes the design under rtl/; counts are latched by manual update.
`timescale 1ns/1ps
module line_error_performance_counters_test;
  logic       i_mclk, i_sys_rst, i_e1_mode, i_esf_mode, i_crc4_mode;
  logic       i_zcs_enable, i_manual_update, i_mark_valid, i_mark_pos;
  logic       i_mark_neg, i_codeword_valid, i_crc_error, i_ft_error;
  logic       i_fs_error, i_fps_error, i_fas_error, i_multiframe_end;
  logic       i_multiframe_out_of_sync, i_ebit_valid, i_ebit_value;
  logic       i_receive_frame_loss, i_fas_sync_loss, i_crc4_sync_loss;
  logic       i_cas_sync_loss, i_fas_search, i_cas_search, i_crc4_search;
  logic [2:0] i_counter_configuration;
  logic [1:0] i_update_select;
  logic [3:0] i_frame_number;
  logic [7:0] o_line_violation_count_hi, o_line_violation_count_lo;
  logic [7:0] o_path_violation_count_hi, o_path_violation_count_lo;
  logic [7:0] o_sync_error_count_hi, o_sync_error_count_lo;
  logic [7:0] o_far_end_block_count_hi, o_far_end_block_count_lo;
  logic       o_frame_loss, o_update_timer_pulse;
  int         miscompares, samples_checked;
  localparam logic [5:0] MFE = 6'h20, CRC = 6'h10, FT = 6'h08;
  localparam logic [5:0] FS = 6'h04, FPS = 6'h02, FAS = 6'h01;

  line_error_performance_counters uut (
    .i_mclk, .i_sys_rst, .i_e1_mode, .i_esf_mode, .i_crc4_mode,
    .i_zcs_enable, .i_counter_configuration, .i_update_select,
    .i_manual_update, .i_mark_valid, .i_mark_pos, .i_mark_neg,
    .i_codeword_valid, .i_crc_error, .i_ft_error, .i_fs_error,
    .i_fps_error, .i_fas_error, .i_multiframe_end,
    .i_multiframe_out_of_sync, .i_ebit_valid, .i_ebit_value,
    .i_frame_number, .i_receive_frame_loss, .i_fas_sync_loss,
    .i_crc4_sync_loss, .i_cas_sync_loss, .i_fas_search, .i_cas_search,
    .i_crc4_search, .o_line_violation_count_hi,
    .o_line_violation_count_lo, .o_path_violation_count_hi,
    .o_path_violation_count_lo, .o_sync_error_count_hi,
    .o_sync_error_count_lo, .o_far_end_block_count_hi,
    .o_far_end_block_count_lo, .o_frame_loss, .o_update_timer_pulse
  );

  // ********************************************************
  // Access tasks
  // ********************************************************
  task automatic complete_run();
    if (miscompares == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk_all(input logic [15:0] l, p, s, f);
    chk({o_line_violation_count_hi, o_line_violation_count_lo}, l);
    chk({o_path_violation_count_hi, o_path_violation_count_lo}, p);
    chk({o_sync_error_count_hi, o_sync_error_count_lo}, s);
    chk({o_far_end_block_count_hi, o_far_end_block_count_lo}, f);
  endtask

  // One-cycle framer event pulses, a quiet cycle between them
  task automatic ev(input logic [5:0] v, input int n);
    repeat (n) begin
      @(negedge i_mclk);
      {i_multiframe_end, i_crc_error, i_ft_error, i_fs_error,
       i_fps_error, i_fas_error} = v;
      @(negedge i_mclk);
      {i_multiframe_end, i_crc_error, i_ft_error, i_fs_error,
       i_fps_error, i_fas_error} = 6'h00;
    end
  endtask

  // Received bits: 0 zero, 1 positive mark, 2 negative mark
  task automatic mk(input int p, input logic cw, input int n);
    repeat (n) begin
      @(negedge i_mclk);
      i_mark_valid = 1'b1;
      i_mark_pos = (p == 1);
      i_mark_neg = (p == 2);
      i_codeword_valid = cw;
      @(negedge i_mclk);
      {i_mark_valid, i_mark_pos, i_mark_neg, i_codeword_valid} = 4'h0;
    end
  endtask

  task automatic ebit(input logic [3:0] f, input logic v);
    @(negedge i_mclk);
    {i_ebit_valid, i_ebit_value, i_frame_number} = {1'b1, v, f};
    @(negedge i_mclk);
    i_ebit_valid = 1'b0;
  endtask

  // Manual pin pulse, then time for the synchroniser and snapshot
  task automatic latch();
    @(negedge i_mclk);
    i_manual_update = 1'b1;
    repeat (2) @(negedge i_mclk);
    i_manual_update = 1'b0;
    repeat (6) @(negedge i_mclk);
  endtask

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  initial begin
    #400000;
    miscompares++;
    complete_run();
  end

  // ********************************************************
  // Test sequence
  // ********************************************************
  initial begin
    {i_e1_mode, i_esf_mode, i_crc4_mode, i_zcs_enable, i_manual_update,
     i_mark_valid, i_mark_pos, i_mark_neg, i_codeword_valid, i_crc_error,
     i_ft_error, i_fs_error, i_fps_error, i_fas_error, i_multiframe_end,
     i_multiframe_out_of_sync, i_ebit_valid, i_ebit_value,
     i_receive_frame_loss, i_fas_sync_loss, i_crc4_sync_loss,
     i_cas_sync_loss, i_fas_search, i_cas_search, i_crc4_search} = '0;
    {i_counter_configuration, i_frame_number} = 7'h00;
    i_update_select = 2'h2;
    i_sys_rst = 1'b1;
    miscompares = 0;
    samples_checked = 0;
    repeat (8) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    latch();
    chk_all(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    chk({15'h0000, o_update_timer_pulse}, 16'h0000);
    i_counter_configuration = 3'h2;
    ev(FT, 3);
    ev(FS, 2);
    latch();
    chk_all(16'h0000, 16'h0003, 16'h0003, 16'h0000);
    i_update_select = 2'h0;
    ev(FT, 1);
    latch();
    chk_all(16'h0000, 16'h0003, 16'h0003, 16'h0000);
    i_update_select = 2'h2;
    i_counter_configuration = 3'h6;
    ev(FS, 2);
    ev(FT, 1);
    latch();
    chk_all(16'h0000, 16'h0004, 16'h0002, 16'h0000);
    i_esf_mode = 1'b1;
    i_counter_configuration = 3'h2;
    ev(CRC, 4);
    ev(FPS, 2);
    latch();
    chk_all(16'h0000, 16'h0004, 16'h0002, 16'h0000);
    i_esf_mode = 1'b0;
    i_receive_frame_loss = 1'b1;
    ev(FT, 2);
    mk(1, 1'b0, 2);
    mk(2, 1'b0, 2);
    chk({15'h0000, o_frame_loss}, 16'h0001);
    latch();
    chk_all(16'h0002, 16'h0000, 16'h0000, 16'h0000);
    i_counter_configuration = 3'h0;
    i_multiframe_out_of_sync = 1'b1;
    ev(MFE, 3);
    i_multiframe_out_of_sync = 1'b0;
    ev(MFE, 1);
    i_receive_frame_loss = 1'b0;
    latch();
    chk_all(16'h0000, 16'h0000, 16'h0003, 16'h0000);
    chk({15'h0000, o_frame_loss}, 16'h0000);
    i_zcs_enable = 1'b1;
    mk(1, 1'b0, 1);
    mk(1, 1'b1, 1);
    mk(2, 1'b0, 2);
    latch();
    chk_all(16'h0001, 16'h0000, 16'h0000, 16'h0000);
    i_zcs_enable = 1'b0;
    i_counter_configuration = 3'h1;
    mk(1, 1'b0, 1);
    mk(0, 1'b0, 32);
    mk(2, 1'b0, 1);
    latch();
    chk_all(16'h0002, 16'h0000, 16'h0000, 16'h0000);
    i_zcs_enable = 1'b1;
    mk(1, 1'b0, 1);
    mk(0, 1'b0, 23);
    mk(2, 1'b0, 1);
    latch();
    chk_all(16'h0002, 16'h0000, 16'h0000, 16'h0000);
    i_zcs_enable = 1'b0;
    i_e1_mode = 1'b1;
    i_counter_configuration = 3'h0;
    mk(1, 1'b0, 2);
    mk(2, 1'b0, 2);
    latch();
    chk_all(16'h0002, 16'h0000, 16'h0000, 16'h0000);
    i_counter_configuration = 3'h1;
    i_zcs_enable = 1'b1;
    mk(1, 1'b0, 1);
    mk(2, 1'b0, 2);
    mk(1, 1'b0, 2);
    latch();
    chk_all(16'h0001, 16'h0000, 16'h0000, 16'h0000);
    i_zcs_enable = 1'b0;
    i_counter_configuration = 3'h0;
    i_crc4_mode = 1'b1;
    ev(CRC | FAS, 2);
    i_fas_sync_loss = 1'b1;
    ev(CRC, 1);
    ebit(4'hf, 1'b0);
    i_fas_sync_loss = 1'b0;
    i_crc4_sync_loss = 1'b1;
    ev(CRC, 1);
    ebit(4'hd, 1'b0);
    i_crc4_sync_loss = 1'b0;
    i_cas_sync_loss = 1'b1;
    ev(CRC, 3);
    ebit(4'hd, 1'b0);
    i_cas_sync_loss = 1'b0;
    i_receive_frame_loss = 1'b1;
    ev(FAS, 1);
    i_receive_frame_loss = 1'b0;
    i_fas_search = 1'b1;
    ev(FAS, 1);
    i_fas_search = 1'b0;
    i_cas_search = 1'b1;
    ev(FAS, 1);
    i_cas_search = 1'b0;
    i_crc4_search = 1'b1;
    ev(FAS, 1);
    i_crc4_search = 1'b0;
    ebit(4'hd, 1'b0);
    ebit(4'hf, 1'b0);
    ebit(4'hd, 1'b1);
    ebit(4'hc, 1'b0);
    i_crc4_mode = 1'b0;
    ebit(4'hf, 1'b0);
    latch();
    chk_all(16'h0000, 16'h0005, 16'h0002, 16'h0003);
    i_e1_mode = 1'b0;
    // Back-to-back same-polarity marks saturate the line count
    @(negedge i_mclk);
    {i_mark_valid, i_mark_pos} = 2'h3;
    repeat (65540) @(negedge i_mclk);
    {i_mark_valid, i_mark_pos} = 2'h0;
    latch();
    chk_all(16'hffff, 16'h0000, 16'h0000, 16'h0000);
    latch();
    chk_all(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    complete_run();
  end
endmodule
